// [include/remap_out_map.svh]
// Purpose: offsets, field positions and reset values of the output remap
// Assumes: included by bare name from package and design files
// Notes: offsets are byte addresses on the register bus
`ifndef REMAP_OUT_MAP_SVH
`define REMAP_OUT_MAP_SVH
`define ROS_OFF_PINS_0_1 4'h0
`define ROS_OFF_PINS_2_3 4'h4
`define ROS_OFF_PINS_4_5 4'h8
`define ROS_ADDR_W 4
`define ROS_REG_W 16
`define ROS_SEL_W 5
`define ROS_LO_LSB 0
`define ROS_HI_LSB 8
`define ROS_REG_CNT 3
`define ROS_PIN_CNT 6
`define ROS_SEL_RESET 5'h0_0
`define ROS_SEL_NONE 5'h0_0
`define ROS_FUNC_CNT 32
`define ROS_RESP_OKAY 2'h0
`define ROS_RESP_SLVERR 2'h2
`endif

// [include/remap_out_pkg.sv]
// Purpose: shared types of the output remap block
// Assumes: map header provides widths
// Notes: none
`include "remap_out_map.svh"
package remap_out_pkg;
	// one selector field
	typedef logic [`ROS_SEL_W-1:0] sel_t;
	// selectors for all pins
	typedef sel_t [`ROS_PIN_CNT-1:0] sel_vec_t;
	// peripheral function outputs, index = function number
	typedef logic [`ROS_FUNC_CNT-1:0] func_vec_t;
endpackage

// [include/remap_sel_if.sv]
// Purpose: carries selector values from register file to pin mux
// Assumes: one clock domain
// Notes: none
`timescale 1ns/100ps
interface remap_sel_if;
	import remap_out_pkg::*;
	sel_vec_t sel; // per-pin function select
	modport regs (output sel);
	modport mux (input sel);
endinterface

// [src/remap_pin_mux.sv]
// Purpose: routes peripheral function outputs onto remappable pins
// Assumes: selectors come from the register file, same clock
// Notes: outputs registered; selector zero gives port pin back
`timescale 1ns/100ps
`include "remap_out_map.svh"
module remap_pin_mux (
	input wire logic aclk,
	input wire logic aresetn,
	remap_sel_if.mux sel_bus,
	input wire remap_out_pkg::func_vec_t func_out,
	input wire logic [`ROS_PIN_CNT-1:0] port_out,
	output logic [`ROS_PIN_CNT-1:0] pin_out_r,
	output logic [`ROS_PIN_CNT-1:0] pin_remapped_r
);
	import remap_out_pkg::*;

	logic [`ROS_PIN_CNT-1:0] pin_out_nxt;
	logic [`ROS_PIN_CNT-1:0] pin_remapped_nxt;

	// selector to one signal; used per pin
	function automatic logic pick(input func_vec_t f, input sel_t s);
		pick = f[s];
	endfunction

	// next pin values
	always_comb begin
		for (int i = 0; i < `ROS_PIN_CNT; i++) begin
			pin_remapped_nxt[i] = (sel_bus.sel[i] != `ROS_SEL_NONE);
			pin_out_nxt[i] = pin_remapped_nxt[i] ?
				pick(func_out, sel_bus.sel[i]) : port_out[i];
		end
	end

	// register the pin drivers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_out_r <= '0;
			pin_remapped_r <= '0;
		end else begin
			pin_out_r <= pin_out_nxt;
			pin_remapped_r <= pin_remapped_nxt;
		end
	end

	property p_route;
		@(posedge aclk) disable iff (!aresetn)
		(sel_bus.sel[0] != `ROS_SEL_NONE) |=>
			pin_out_r[0] == $past(func_out[sel_bus.sel[0]]);
	endproperty
	a_route: assert property (p_route) else $error("pin0 misrouted");

	property p_zero;
		@(posedge aclk) disable iff (!aresetn)
		(sel_bus.sel[1] == `ROS_SEL_NONE) |=>
			(pin_out_r[1] == $past(port_out[1])) && !pin_remapped_r[1];
	endproperty
	a_zero: assert property (p_zero) else $error("pin1 not port");
endmodule

// [src/remappable_output_select.sv]
// Purpose: AXI4-Lite register file for output function selection
// Assumes: aclk 40 MHz, synchronous active-low reset
// Notes: three 16-bit registers, two selectors each
// Functional notes
// - two 5-bit selectors per register
// - pins 2/3 in second register
// - bits 15-13, 7-5 read zero
// - small variant lacks pins 2,3,5
// - selector steers function to pin
//
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "remap_out_map.svh"
module remappable_output_select
#(
	parameter bit SMALL_VARIANT = 1'b0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [`ROS_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`ROS_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire remap_out_pkg::func_vec_t func_out,
	input wire logic [`ROS_PIN_CNT-1:0] port_out,
	output logic [`ROS_PIN_CNT-1:0] pin_out,
	output logic [`ROS_PIN_CNT-1:0] pin_remapped
);
	import remap_out_pkg::*;

	remap_sel_if sel_bus(); // selectors toward mux

	sel_vec_t sel_r; // selector storage
	sel_vec_t sel_nxt;
	logic [`ROS_PIN_CNT-1:0] present; // field exists in this variant

	// write channel state
	logic aw_hold_r, aw_hold_nxt; // address taken, waiting data
	logic w_hold_r, w_hold_nxt; // data taken, waiting address
	logic [`ROS_ADDR_W-1:0] awaddr_r, awaddr_nxt;
	logic [31:0] wdata_r, wdata_nxt;
	logic [3:0] wstrb_r, wstrb_nxt;
	logic bvalid_r, bvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	// read channel state
	logic rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0] rresp_r, rresp_nxt;

	logic aw_fire, w_fire, do_write, ar_fire;
	logic [`ROS_ADDR_W-1:0] wa; // effective write address
	logic [31:0] wd;
	logic [3:0] ws;

	// address to register index; 3 means unmapped
	function automatic logic [1:0] decode(input logic [`ROS_ADDR_W-1:0] a);
		unique case (a)
			`ROS_OFF_PINS_0_1: decode = 2'h0;
			`ROS_OFF_PINS_2_3: decode = 2'h1;
			`ROS_OFF_PINS_4_5: decode = 2'h2;
			default: decode = 2'h3;
		endcase
	endfunction

	// small variant drops pins 2, 3 and 5
	genvar g;
	generate
		for (g = 0; g < `ROS_PIN_CNT; g++) begin : g_present
			assign present[g] = !(SMALL_VARIANT &&
				(g == 2 || g == 3 || g == 5));
		end
	endgenerate

	// single-ported accept: one write and one read at a time
	assign aw_fire = s_axi_awvalid && s_axi_awready;
	assign w_fire = s_axi_wvalid && s_axi_wready;
	assign wa = aw_hold_r ? awaddr_r : s_axi_awaddr;
	assign wd = w_hold_r ? wdata_r : s_axi_wdata;
	assign ws = w_hold_r ? wstrb_r : s_axi_wstrb;
	assign do_write = (aw_hold_r || aw_fire) && (w_hold_r || w_fire);
	assign ar_fire = s_axi_arvalid && s_axi_arready;

	// write side and selector next values
	always_comb begin
		logic [1:0] idx;
		idx = decode(wa);
		sel_nxt = sel_r;
		aw_hold_nxt = aw_hold_r;
		w_hold_nxt = w_hold_r;
		awaddr_nxt = awaddr_r;
		wdata_nxt = wdata_r;
		wstrb_nxt = wstrb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		// response accepted
		if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		if (do_write) begin
			aw_hold_nxt = 1'b0;
			w_hold_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = (idx == 2'h3) ? `ROS_RESP_SLVERR : `ROS_RESP_OKAY;
			if (idx != 2'h3) begin
				// low field even pin, high field odd pin
				// second register holds pins 2 and 3
				if (ws[0] && present[2*idx]) begin
					sel_nxt[2*idx] = wd[`ROS_LO_LSB +: `ROS_SEL_W];
				end
				if (ws[1] && present[2*idx+1]) begin
					sel_nxt[2*idx+1] = wd[`ROS_HI_LSB +: `ROS_SEL_W];
				end
			end
		end else begin
			// hold whichever half arrived first
			if (aw_fire) begin
				aw_hold_nxt = 1'b1;
				awaddr_nxt = s_axi_awaddr;
			end
			if (w_fire) begin
				w_hold_nxt = 1'b1;
				wdata_nxt = s_axi_wdata;
				wstrb_nxt = s_axi_wstrb;
			end
		end
		for (int i = 0; i < `ROS_PIN_CNT; i++) begin
			if (!present[i]) begin
				sel_nxt[i] = `ROS_SEL_RESET;
			end
		end
	end

	// read side next values
	always_comb begin
		logic [1:0] ridx;
		ridx = decode(s_axi_araddr);
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
		if (ar_fire) begin
			rvalid_nxt = 1'b1;
			rdata_nxt = '0;
			rresp_nxt = `ROS_RESP_OKAY;
			if (ridx == 2'h3) begin
				rresp_nxt = `ROS_RESP_SLVERR;
			end else begin
				rdata_nxt[`ROS_LO_LSB +: `ROS_SEL_W] = sel_r[2*ridx];
				rdata_nxt[`ROS_HI_LSB +: `ROS_SEL_W] = sel_r[2*ridx+1];
			end
		end
	end

	// register all state but the readies; selectors reset to zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sel_r <= {`ROS_PIN_CNT{`ROS_SEL_RESET}};
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= '0;
			wstrb_r <= '0;
			bvalid_r <= 1'b0;
			bresp_r <= `ROS_RESP_OKAY;
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= `ROS_RESP_OKAY;
		end else begin
			sel_r <= sel_nxt;
			aw_hold_r <= aw_hold_nxt;
			w_hold_r <= w_hold_nxt;
			awaddr_r <= awaddr_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	// readies are flops: low while holding or answering
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_arready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_hold_nxt && !bvalid_nxt && !do_write;
			s_axi_wready <= !w_hold_nxt && !bvalid_nxt && !do_write;
			s_axi_arready <= !rvalid_nxt && !ar_fire;
		end
	end

	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign sel_bus.sel = sel_r;

	remap_pin_mux u_mux (
		.aclk(aclk),
		.aresetn(aresetn),
		.sel_bus(sel_bus),
		.func_out(func_out),
		.port_out(port_out),
		.pin_out_r(pin_out),
		.pin_remapped_r(pin_remapped)
	);

	// pin 1 from bits 12-8 of first register after full write
	property p_hi_field;
		@(posedge aclk) disable iff (!aresetn)
		(do_write && decode(wa) == 2'h0 && ws[1]) |=>
			sel_r[1] == $past(wd[`ROS_HI_LSB +: `ROS_SEL_W]);
	endproperty
	a_hi_field: assert property (p_hi_field) else $error("pin1 field");

	// pin 2 from low bits of second register
	property p_pin2;
		@(posedge aclk) disable iff (!aresetn)
		(do_write && decode(wa) == 2'h1 && ws[0] && present[2]) |=>
			sel_r[2] == $past(wd[`ROS_LO_LSB +: `ROS_SEL_W]);
	endproperty
	a_pin2: assert property (p_pin2) else $error("pin2 field");

	// reserved bits of read data are zero
	property p_rsvd;
		@(posedge aclk) disable iff (!aresetn)
		rvalid_r |-> (rdata_r[15:13] == 3'h0) && (rdata_r[7:5] == 3'h0);
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits set");

	// absent selectors never hold a value
	property p_absent;
		@(posedge aclk) disable iff (!aresetn)
		SMALL_VARIANT |-> sel_r[2] == 5'h0 && sel_r[3] == 5'h0 &&
			sel_r[5] == 5'h0;
	endproperty
	a_absent: assert property (p_absent) else $error("absent stored");

	// selectors zero one cycle after reset
	property p_reset;
		@(posedge aclk) $rose(aresetn) |-> sel_r == '0;
	endproperty
	a_reset: assert property (p_reset) else $error("not reset");

	// read answer holds with stable data until taken
	property p_rhold;
		@(posedge aclk) disable iff (!aresetn)
		(rvalid_r && !s_axi_rready) |=> rvalid_r && $stable(rdata_r);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read dropped");
endmodule

// [tb/testbench.sv]
// Purpose: self-checking bench for the output remap register file
// Assumes: design and package compiled first
// Notes: both variants share one bus; the small one is only watched
`timescale 1ns/100ps
`include "remap_out_map.svh"
module testbench;
	import remap_out_pkg::*;
	logic aclk = 1'b0; // bus clock
	logic aresetn = 1'b0; // held low at start
	logic [3:0] awaddr = 4'h0;
	logic [3:0] araddr = 4'h0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	func_vec_t func_out = 32'h0000_0000; // peripheral outputs
	logic [5:0] port_out = 6'h2d; // plain port values
	logic [5:0] pin_out, pin_remapped;
	logic [31:0] rdata_s; // small variant read data
	logic [5:0] pin_out_s, pin_remapped_s; // small variant pins
	// pins whose selectors the small variant lacks
	localparam logic [5:0] absent_pins = 6'h2c;
	sel_t sel_m [6]; // expected selectors
	int failures = 0;
	int num_checks = 0;
	int cycles = 0;

	remappable_output_select dut_u (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.func_out(func_out), .port_out(port_out), .pin_out(pin_out),
		.pin_remapped(pin_remapped));

	// small variant on the same bus; its readies match the full one
	remappable_output_select #(.SMALL_VARIANT(1'b1)) dut_small_u (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(), .s_axi_bresp(),
		.s_axi_bvalid(), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(), .s_axi_rdata(rdata_s), .s_axi_rresp(),
		.s_axi_rvalid(), .s_axi_rready(rready),
		.func_out(func_out), .port_out(port_out), .pin_out(pin_out_s),
		.pin_remapped(pin_remapped_s));

	// free-running clock, 25 ns
	always #12.5 aclk = ~aclk;

	// hang guard, far above the hundred or so cycles needed
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			$display("ERROR %0t timeout", $time);
			conclude();
		end
	end

	task conclude;
		if (failures == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t got %h want %h", $time, got, exp);
		end
	endtask

	// handshakes judged at the falling edge, where nothing moves
	task wr(input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [1:0] r);
		logic aw_t, w_t, b_t;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		b_t = 1'b0;
		while (!b_t) begin
			@(negedge aclk);
			aw_t = awvalid && awready;
			w_t = wvalid && wready;
			b_t = bvalid && bready;
			r = bresp;
			@(posedge aclk);
			if (aw_t) awvalid <= 1'b0;
			if (w_t) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		@(posedge aclk);
	endtask

	task rd(input logic [3:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic ar_t, r_t;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		r_t = 1'b0;
		while (!r_t) begin
			@(negedge aclk);
			ar_t = arvalid && arready;
			r_t = rvalid && rready;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ar_t) arvalid <= 1'b0;
		end
		rready <= 1'b0;
		@(posedge aclk);
	endtask

	// write a register with ones in the unused bits
	task put(input int r, input sel_t hi, input sel_t lo,
		input logic [3:0] s);
		logic [1:0] resp;
		wr(4'(4 * r), {16'hffff, 3'h7, hi, 3'h7, lo}, s, resp);
		chk({30'h0, resp}, {30'h0, `ROS_RESP_OKAY});
		if (s[0]) sel_m[2 * r] = lo;
		if (s[1]) sel_m[2 * r + 1] = hi;
	endtask

	// read back, unused bits must be zero
	task rchk(input int r);
		logic [31:0] d;
		logic [1:0] resp;
		sel_t lo_s, hi_s;
		rd(4'(4 * r), d, resp);
		chk(d, {19'h0, sel_m[2 * r + 1], 3'h0, sel_m[2 * r]});
		chk({30'h0, resp}, {30'h0, `ROS_RESP_OKAY});
		// absent fields read zero in the small variant
		lo_s = absent_pins[2 * r] ? 5'h00 : sel_m[2 * r];
		hi_s = absent_pins[2 * r + 1] ? 5'h00 : sel_m[2 * r + 1];
		chk(rdata_s, {19'h0, hi_s, 3'h0, lo_s});
	endtask

	// pins follow selectors and function outputs
	task pins_chk;
		logic [5:0] ep, er, es, ers;
		repeat (2) @(posedge aclk);
		@(negedge aclk);
		for (int i = 0; i < 6; i++) begin
			er[i] = sel_m[i] != 5'h00;
			ep[i] = er[i] ? func_out[sel_m[i]] : port_out[i];
			// small variant keeps absent pins as port pins
			ers[i] = er[i] && !absent_pins[i];
			es[i] = ers[i] ? func_out[sel_m[i]] : port_out[i];
		end
		chk({26'h0, pin_out}, {26'h0, ep});
		chk({26'h0, pin_remapped}, {26'h0, er});
		chk({26'h0, pin_out_s}, {26'h0, es});
		chk({26'h0, pin_remapped_s}, {26'h0, ers});
		@(posedge aclk);
	endtask

	task t_reset;
		for (int r = 0; r < 3; r++)
			rchk(r);
		pins_chk();
	endtask

	task t_fields;
		for (int r = 0; r < 3; r++) begin
			put(r, 5'h1f, 5'h1f, 4'hf);
			rchk(r);
		end
	endtask

	task t_route;
		put(0, 5'h1f, 5'h01, 4'hf);
		put(1, 5'h00, 5'h02, 4'hf);
		put(2, 5'h05, 5'h11, 4'hf);
		func_out <= 32'h8002_0020;
		pins_chk();
		func_out <= 32'h7ffd_ffdf;
		port_out <= 6'h12;
		pins_chk();
	endtask

	task t_strobe;
		put(1, 5'h0a, 5'h15, 4'h2);
		rchk(1);
		put(0, 5'h03, 5'h00, 4'h1);
		rchk(0);
		pins_chk();
	endtask

	// read answer must stand while rready is held off
	task t_late_ready;
		logic [31:0] d;
		d = {19'h0, sel_m[3], 3'h0, sel_m[2]};
		araddr <= 4'h4;
		arvalid <= 1'b1;
		@(negedge aclk);
		while (!arready) begin
			@(negedge aclk);
		end
		@(posedge aclk);
		arvalid <= 1'b0;
		repeat (3) @(posedge aclk);
		@(negedge aclk);
		chk({31'h0, rvalid}, 32'h0000_0001);
		chk(rdata, d);
		chk(rdata_s, 32'h0000_0000);
		@(posedge aclk);
		rready <= 1'b1;
		@(posedge aclk);
		rready <= 1'b0;
		@(posedge aclk);
	endtask

	task t_unmapped;
		logic [31:0] d;
		logic [1:0] resp;
		wr(4'hc, 32'hffff_ffff, 4'hf, resp);
		chk({30'h0, resp}, {30'h0, `ROS_RESP_SLVERR});
		rd(4'hc, d, resp);
		chk(d, 32'h0000_0000);
		chk({30'h0, resp}, {30'h0, `ROS_RESP_SLVERR});
		for (int r = 0; r < 3; r++)
			rchk(r);
	endtask

	initial begin
		for (int i = 0; i < 6; i++)
			sel_m[i] = 5'h00;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		t_reset();
		t_fields();
		t_route();
		t_strobe();
		t_late_ready();
		t_unmapped();
		conclude();
	end
endmodule
